// >>> cpu_core_model.sv
// behavioural cpu core that drives the timer register port and the vector pulses
`timescale 1ns/10ps
module cpu_core_model
(
  // clock
  input  wire logic       clock_in,
  // register port
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  // vector pulses: timer0, timer1, ext0, ext1
  output logic      [3:0] vector_out
);
  // quiet bus at time zero
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    vector_out = 4'h0;
  end

  // one-cycle write; the strobe drops on the next edge, so calls never collide
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock_in);
    addr_out <= addr;
    wdata_out <= data;
    wr_out <= 1'b1;
    @(posedge clock_in);
    wr_out <= 1'b0;
    wdata_out <= ~data;
  endtask

  // read data stand only in the cycle after the strobe, so sample it there
  task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clock_in);
    addr_out <= addr;
    rd_out <= 1'b1;
    @(posedge clock_in);
    rd_out <= 1'b0;
    @(negedge clock_in);
    data = rdata_in;
  endtask

  // core vectoring to one interrupt routine
  task automatic vector(input int idx);
    @(posedge clock_in);
    vector_out[idx] <= 1'b1;
    @(posedge clock_in);
    vector_out <= 4'h0;
  endtask
endmodule

// >>> dual_timer_counter_pwm.sv
// two 16-bit timer/counters with edge-aligned pulse outputs
//
// Contract
// - overflow flag set by hardware on overflow, cleared on interrupt vectoring.
// - a timer counts only while its run bit is set.
// - external interrupt edge flag set on detected edge, cleared when processed.
// - type bit set selects falling edge, cleared selects low level.
// - gate bit set: count only while irq pin high and run set.
// - select bit clear counts system clock, set counts timer pin events.
// - mode 00: high byte counter fed by 1 to 8 bit low-byte prescaler.
// - mode 01: 16-bit counter reloading from the reload pair on overflow.
// - mode 10: low byte counts, reloads from high byte on overflow.
// - timer 0 mode 11: low byte own controls, high byte uses timer 1's.
// - timer 1 in mode 11 holds its count.
// - mode 0 active low bits equal width field plus one, reset 100B.
// - pulse enable makes an 8-bit edge-aligned modulator on the timer pin.
// - overflow flags and timer 1 keep working during pulse operation.
// - pulse operation has four modes chosen by the mode bits.
// - output high when high byte is 00H, low at compare match.
// - duty register reaches compare latch only on FFH to 00H rollover.
// - duty 00H keeps the output low.
// - pulse mode 0 low byte is a logarithmic prescaler for the high byte.
// - pulse mode 0 frequency is clock over 256 times two power width; the code divides the tick by 256 times two power (width plus one).
// - both timers share one rate divider dividing by 1 to 16.
// - counter mode increments after a high sample followed by a low one.
`timescale 1ns/10ps
module dual_timer_counter_pwm
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // interrupt vectoring from the core
  input  wire logic       timer0_vector_in,
  input  wire logic       timer1_vector_in,
  input  wire logic       ext0_vector_in,
  input  wire logic       ext1_vector_in,
  // flags towards the interrupt controller
  output logic            timer0_overflow_out,
  output logic            timer1_overflow_out,
  output logic            ext_irq0_edge_out,
  output logic            ext_irq1_edge_out,
  // pins
  input  wire logic       ext_irq0_pin_n_in,
  input  wire logic       ext_irq1_pin_n_in,
  input  wire logic       timer0_pin_in,
  input  wire logic       timer1_pin_in,
  output logic            timer0_pin_out,
  output logic            timer0_pin_oe_out,
  output logic            timer1_pin_out,
  output logic            timer1_pin_oe_out
);
  import timer_pkg::*;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic       timer0_run_bit, timer1_run_bit;
  logic       ext_irq0_type_bit, ext_irq1_type_bit;
  logic [7:0] timer_mode, timer_control_second;
  logic [3:0] shared_rate_divider, rate_count;
  logic [7:0] tl0, th0, tl1, th1, rl0, rh0, rl1, rh1;
  logic [7:0] compare0, compare1;
  logic       irq0_s1, irq0_s2, irq1_s1, irq1_s2;
  logic       pin0_s1, pin0_s2, pin1_s1, pin1_s2;
  logic [7:0] next_tl0, next_th0, next_tl1, next_th1;
  logic       set_ovf0, set_ovf1, tick, ev0, ev1;
  logic [16:0] step0, step1;
  logic [7:0] read_mux;

  wire wr_ctl = wr_in && addr_in == CONTROL_ADDR;
  wire [1:0] md0 = timer_mode[MODE_LSB +: 2];
  wire [1:0] md1 = timer_mode[T1_SHIFT + MODE_LSB +: 2];
  wire [2:0] wd0 = timer_control_second[WIDTH0_LSB +: 3];
  wire [2:0] wd1 = timer_control_second[WIDTH1_LSB +: 3];

  // -------------------------------------------------------------------
  // one counting step of a timer: {overflow, high, low}
  // -------------------------------------------------------------------
  function automatic logic [16:0] step(input logic [1:0] md, input logic [2:0] wd,
                                       input logic [7:0] lo, input logic [7:0] hi,
                                       input logic [7:0] rlo, input logic [7:0] rhi);
    logic [7:0] mask;
    logic       carry;
    mask  = 8'hff >> (3'h7 - wd);
    carry = (lo & mask) == mask;
    step  = {1'b0, hi, lo};
    unique case (md)
      // low byte prescales the high byte, shared by pulse mode 0
      MODE_VAR:
      begin
        step[7:0]  = (lo + 8'h01) & mask;
        step[15:8] = carry ? hi + 8'h01 : hi;
        step[16]   = carry && hi == 8'hff;
      end
      MODE_16:
      begin
        if ({hi, lo} == 16'hffff)
          step = {1'b1, rhi, rlo};
        else
          step = {1'b0, {hi, lo} + 16'h0001};
      end
      MODE_8RL:
      begin
        step[16]  = lo == 8'hff;
        step[7:0] = lo == 8'hff ? hi : lo + 8'h01;
      end
      MODE_SPLIT:
      begin
        step[16]  = lo == 8'hff;
        step[7:0] = lo + 8'h01;
      end
    endcase
  endfunction

  // -------------------------------------------------------------------
  // shared rate divider and pin sampling
  // -------------------------------------------------------------------
  assign tick = rate_count == shared_rate_divider;

  // divider free-runs so both timers see the same tick
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rate_count <= DIVIDER_RESET;
    else
      rate_count <= tick ? 4'h0 : rate_count + 4'h1;
  end

  // pins are synchronous; two samples give the falling edge
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      {irq0_s1, irq0_s2, irq1_s1, irq1_s2} <= 4'hf;
      {pin0_s1, pin0_s2, pin1_s1, pin1_s2} <= 4'h0;
    end
    else
    begin
      irq0_s1 <= ext_irq0_pin_n_in;
      irq0_s2 <= irq0_s1;
      irq1_s1 <= ext_irq1_pin_n_in;
      irq1_s2 <= irq1_s1;
      pin0_s1 <= timer0_pin_in;
      pin0_s2 <= pin0_s1;
      pin1_s1 <= timer1_pin_in;
      pin1_s2 <= pin1_s1;
    end
  end

  // -------------------------------------------------------------------
  // count events and next counts
  // -------------------------------------------------------------------
  // gate lets the irq pin measure pulse widths
  wire run0 = timer0_run_bit && (!timer_mode[GATE_BIT] || irq0_s1);
  wire run1 = timer1_run_bit && (!timer_mode[T1_SHIFT + GATE_BIT] || irq1_s1);

  always_comb
  begin
    ev0 = run0 && (timer_mode[SEL_BIT] ? (pin0_s2 && !pin0_s1) : tick);
    ev1 = run1 && md1 != MODE_SPLIT
          && (timer_mode[T1_SHIFT + SEL_BIT] ? (pin1_s2 && !pin1_s1) : tick);
    step0 = step(md0, wd0, tl0, th0, rl0, rh0);
    step1 = step(md1, wd1, tl1, th1, rl1, rh1);
    next_tl0 = tl0;
    next_th0 = th0;
    next_tl1 = tl1;
    next_th1 = th1;
    set_ovf0 = 1'b0;
    set_ovf1 = 1'b0;
    if (ev0)
    begin
      next_tl0 = step0[7:0];
      if (md0 != MODE_SPLIT)
        next_th0 = step0[15:8];
      set_ovf0 = step0[16];
    end
    // split mode: high byte of timer 0 is a plain timer on timer 1's run bit
    if (md0 == MODE_SPLIT && timer1_run_bit && tick)
    begin
      next_th0 = th0 + 8'h01;
      set_ovf1 = th0 == 8'hff;
    end
    if (ev1)
    begin
      next_tl1 = step1[7:0];
      next_th1 = step1[15:8];
      // timer 1 keeps counting (baud source) but loses its flag in split mode
      if (md0 != MODE_SPLIT)
        set_ovf1 = step1[16];
    end
  end

  // -------------------------------------------------------------------
  // counter and reload registers; a software write beats the count
  // -------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      {tl0, th0, tl1, th1} <= {4{COUNT_RESET}};
      {rl0, rh0, rl1, rh1} <= {4{COUNT_RESET}};
    end
    else
    begin
      tl0 <= (wr_in && addr_in == T0_LOW_ADDR) ? wdata_in : next_tl0;
      th0 <= (wr_in && addr_in == T0_HIGH_ADDR) ? wdata_in : next_th0;
      tl1 <= (wr_in && addr_in == T1_LOW_ADDR) ? wdata_in : next_tl1;
      th1 <= (wr_in && addr_in == T1_HIGH_ADDR) ? wdata_in : next_th1;
      if (wr_in && addr_in == T0_RLOW_ADDR)
        rl0 <= wdata_in;
      if (wr_in && addr_in == T0_RHIGH_ADDR)
        rh0 <= wdata_in;
      if (wr_in && addr_in == T1_RLOW_ADDR)
        rl1 <= wdata_in;
      if (wr_in && addr_in == T1_RHIGH_ADDR)
        rh1 <= wdata_in;
    end
  end

  // -------------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      timer_mode           <= MODE_RESET;
      timer_control_second <= SECOND_RESET;
      shared_rate_divider  <= DIVIDER_RESET;
      {timer1_run_bit, timer0_run_bit}       <= 2'h0;
      {ext_irq1_type_bit, ext_irq0_type_bit} <= 2'h0;
    end
    else
    begin
      if (wr_in && addr_in == MODE_ADDR)
        timer_mode <= wdata_in;
      if (wr_in && addr_in == SECOND_ADDR)
        timer_control_second <= wdata_in;
      if (wr_in && addr_in == DIVIDER_ADDR)
        shared_rate_divider <= wdata_in[3:0];
      if (wr_ctl)
      begin
        timer1_run_bit    <= wdata_in[RUN1_BIT];
        timer0_run_bit    <= wdata_in[RUN0_BIT];
        ext_irq1_type_bit <= wdata_in[TYP1_BIT];
        ext_irq0_type_bit <= wdata_in[TYP0_BIT];
      end
    end
  end

  // -------------------------------------------------------------------
  // flags: a hardware set wins over a vector clear or a write
  // -------------------------------------------------------------------
  wire fall0 = irq0_s2 && !irq0_s1;
  wire fall1 = irq1_s2 && !irq1_s1;
  // level mode mirrors the pin, so a held-low request keeps asking
  wire ext_set0 = ext_irq0_type_bit ? fall0 : !irq0_s1;
  wire ext_set1 = ext_irq1_type_bit ? fall1 : !irq1_s1;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      timer0_overflow_out <= 1'b0;
      timer1_overflow_out <= 1'b0;
      ext_irq0_edge_out   <= 1'b0;
      ext_irq1_edge_out   <= 1'b0;
    end
    else
    begin
      timer0_overflow_out <= set_ovf0 || (wr_ctl ? wdata_in[OVF0_BIT]
                             : timer0_overflow_out && !timer0_vector_in);
      timer1_overflow_out <= set_ovf1 || (wr_ctl ? wdata_in[OVF1_BIT]
                             : timer1_overflow_out && !timer1_vector_in);
      ext_irq0_edge_out   <= ext_set0 || (wr_ctl ? wdata_in[EDG0_BIT]
                             : ext_irq0_type_bit && ext_irq0_edge_out && !ext0_vector_in);
      ext_irq1_edge_out   <= ext_set1 || (wr_ctl ? wdata_in[EDG1_BIT]
                             : ext_irq1_type_bit && ext_irq1_edge_out && !ext1_vector_in);
    end
  end

  // -------------------------------------------------------------------
  // pulse outputs: compare latches load only at high-byte rollover
  // -------------------------------------------------------------------
  wire roll0 = th0 == 8'hff && next_th0 == 8'h00;
  wire roll1 = th1 == 8'hff && next_th1 == 8'h00;

  // latch is invisible to software so a mid-period duty write cannot glitch
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      compare0 <= COUNT_RESET;
      compare1 <= COUNT_RESET;
    end
    else
    begin
      if (roll0)
        compare0 <= rh0;
      if (roll1)
        compare1 <= rh1;
    end
  end

  // match wins over the 00H set, so a zero duty stays low
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      timer0_pin_out <= 1'b0;
      timer1_pin_out <= 1'b0;
    end
    else
    begin
      if (th0 == compare0)
        timer0_pin_out <= 1'b0;
      else if (th0 == 8'h00)
        timer0_pin_out <= 1'b1;
      if (th1 == compare1)
        timer1_pin_out <= 1'b0;
      else if (th1 == 8'h00)
        timer1_pin_out <= 1'b1;
    end
  end

  // pin drive follows the enable bits; a flop copy keeps outputs registered
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      timer0_pin_oe_out <= SECOND_RESET[PULSE0_BIT];
      timer1_pin_oe_out <= SECOND_RESET[PULSE1_BIT];
    end
    else
    begin
      timer0_pin_oe_out <= timer_control_second[PULSE0_BIT];
      timer1_pin_oe_out <= timer_control_second[PULSE1_BIT];
    end
  end

  // -------------------------------------------------------------------
  // read port: data stand one cycle after the strobe, else zero
  // -------------------------------------------------------------------
  always_comb
  begin
    unique case (addr_in)
      CONTROL_ADDR:  read_mux = {timer1_overflow_out, timer1_run_bit,
                                 timer0_overflow_out, timer0_run_bit,
                                 ext_irq1_edge_out, ext_irq1_type_bit,
                                 ext_irq0_edge_out, ext_irq0_type_bit};
      MODE_ADDR:     read_mux = timer_mode;
      T0_LOW_ADDR:   read_mux = tl0;
      T1_LOW_ADDR:   read_mux = tl1;
      T0_HIGH_ADDR:  read_mux = th0;
      T1_HIGH_ADDR:  read_mux = th1;
      DIVIDER_ADDR:  read_mux = {4'h0, shared_rate_divider};
      SECOND_ADDR:   read_mux = timer_control_second;
      T0_RLOW_ADDR:  read_mux = rl0;
      T1_RLOW_ADDR:  read_mux = rl1;
      T0_RHIGH_ADDR: read_mux = rh0;
      T1_RHIGH_ADDR: read_mux = rh1;
      default:       read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 8'h00;
    else
      rdata_out <= rd_in ? read_mux : 8'h00;
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence irq0_fall_s;
    irq0_s1 ##1 !irq0_s1;
  endsequence

  sequence pin0_fall_s;
    pin0_s1 ##1 !pin0_s1;
  endsequence

  wire no_wr0 = !(wr_in && (addr_in == T0_LOW_ADDR || addr_in == T0_HIGH_ADDR));

  ovf_sets_a: assert property (
    md0 == MODE_16 && ev0 && {th0, tl0} == 16'hffff |=> timer0_overflow_out
                                                        && {th0, tl0} == $past({rh0, rl0}))
    else $error("timer 0 overflow did not flag and reload");
  run_holds_a: assert property (
    !timer0_run_bit && no_wr0 |=> tl0 == $past(tl0))
    else $error("timer 0 counted while stopped");
  edge_flag_a: assert property (
    ext_irq0_type_bit ##0 irq0_fall_s |=> ext_irq0_edge_out)
    else $error("edge flag missed a falling edge");
  level_flag_a: assert property (
    !ext_irq0_type_bit && !irq0_s1 |=> ext_irq0_edge_out)
    else $error("level request not flagged");
  gate_blocks_a: assert property (
    timer_mode[GATE_BIT] && !irq0_s1 && no_wr0 |=> $stable(tl0))
    else $error("gated timer counted with pin low");
  pin_event_a: assert property (
    pin0_fall_s ##0 (timer_mode[SEL_BIT] && run0 && md0 == MODE_8RL && tl0 != 8'hff && no_wr0)
    |=> tl0 == $past(tl0) + 8'h01)
    else $error("counter missed a pin event");
  reload8_a: assert property (
    md0 == MODE_8RL && ev0 && tl0 == 8'hff && no_wr0 |=> tl0 == $past(th0) && $stable(th0))
    else $error("8-bit reload wrong");
  hold1_a: assert property (
    md1 == MODE_SPLIT && !wr_in |=> $stable({th1, tl1}))
    else $error("timer 1 counted in split mode");
  compare_load_a: assert property (
    !$stable(compare0) |-> $past(roll0))
    else $error("compare latch changed outside rollover");
  zero_duty_a: assert property (
    compare0 == 8'h00 [*2] |-> !timer0_pin_out)
    else $error("zero duty output went high");
endmodule

// >>> tb_top.sv
// self-checking testbench for the dual timer/counter with pulse outputs
`timescale 1ns/10ps
module tb_top;
  import timer_pkg::*;
  logic clock_in, rst_n_in, pin0, pin1, irq0_n, irq1_n;
  logic [7:0] addr, wdata, rdata, v;
  logic wr, rd, ovf0, ovf1, edg0, edg1, out0, oe0, out1, oe1;
  logic [3:0] vec;
  int n_checks = 0;
  int n_mismatch = 0;
  int n, m;

  dual_timer_counter_pwm i_dual_timer_counter_pwm (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .timer0_vector_in(vec[0]), .timer1_vector_in(vec[1]), .ext0_vector_in(vec[2]),
    .ext1_vector_in(vec[3]), .timer0_overflow_out(ovf0), .timer1_overflow_out(ovf1),
    .ext_irq0_edge_out(edg0), .ext_irq1_edge_out(edg1), .ext_irq0_pin_n_in(irq0_n),
    .ext_irq1_pin_n_in(irq1_n), .timer0_pin_in(pin0), .timer1_pin_in(pin1),
    .timer0_pin_out(out0), .timer0_pin_oe_out(oe0), .timer1_pin_out(out1),
    .timer1_pin_oe_out(oe1));
  cpu_core_model i_cpu_core_model (.clock_in(clock_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .vector_out(vec));

  // 40 MHz clock
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    i_cpu_core_model.sfr_write(a, d);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    i_cpu_core_model.sfr_read(a, v);
    check({8'h00, v}, {8'h00, exp});
  endtask

  task automatic cycles(input int c);
    repeat (c) @(posedge clock_in);
  endtask

  // bounded wait: 0 ovf0, 1 ovf1, 2 pulse low, 3 pulse high
  task automatic wait_sig(input int sel, input int bound);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < bound && !hit; i++)
    begin
      @(negedge clock_in);
      case (sel)
        0: hit = (ovf0 === 1'b1);
        1: hit = (ovf1 === 1'b1);
        2: hit = (out0 === 1'b0);
        default: hit = (out0 === 1'b1);
      endcase
    end
    if (!hit)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      end_of_test();
    end
  endtask

  // high samples over one 512-cycle pulse period
  task automatic count_high(output int c);
    c = 0;
    repeat (512)
    begin
      if (out0 === 1'b1)
        c++;
      @(negedge clock_in);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst_n_in = 1'b0;
    pin0 = 1'b1;
    pin1 = 1'b1;
    irq0_n = 1'b1;
    irq1_n = 1'b1;
    cycles(6);
    rst_n_in <= 1'b1;
    // reset values, read-back and an unmapped place
    rd_check(CONTROL_ADDR, 8'h00);
    rd_check(SECOND_ADDR, 8'h24);
    rd_check(8'h80, 8'h00);
    wr_reg(MODE_ADDR, 8'h5a);
    rd_check(MODE_ADDR, 8'h5a);
    // mode 2 reload from the high byte
    wr_reg(T0_HIGH_ADDR, 8'hf0);
    wr_reg(T0_LOW_ADDR, 8'hfa);
    wr_reg(MODE_ADDR, 8'h02);
    wr_reg(CONTROL_ADDR, 8'h10);
    wait_sig(0, 40);
    wr_reg(CONTROL_ADDR, 8'h20);
    rd_check(T0_HIGH_ADDR, 8'hf0);
    i_cpu_core_model.sfr_read(T0_LOW_ADDR, v);
    check(v >= 8'hf0, 1);
    cycles(10);
    rd_check(T0_LOW_ADDR, v);
    i_cpu_core_model.vector(0);
    cycles(2);
    check(ovf0, 0);
    // shared divider set to divide by four
    wr_reg(DIVIDER_ADDR, 8'h03);
    wr_reg(T0_LOW_ADDR, 8'h00);
    wr_reg(CONTROL_ADDR, 8'h10);
    cycles(40);
    wr_reg(CONTROL_ADDR, 8'h00);
    i_cpu_core_model.sfr_read(T0_LOW_ADDR, v);
    check(v >= 8'h09 && v <= 8'h0c, 1);
    wr_reg(DIVIDER_ADDR, 8'h00);
    // counter mode counts pin falls only
    wr_reg(MODE_ADDR, 8'h06);
    wr_reg(T0_LOW_ADDR, 8'h00);
    wr_reg(CONTROL_ADDR, 8'h10);
    repeat (3)
    begin
      pin0 <= 1'b0;
      cycles(2);
      pin0 <= 1'b1;
      cycles(2);
    end
    wr_reg(CONTROL_ADDR, 8'h00);
    rd_check(T0_LOW_ADDR, 8'h03);
    // gate: low irq pin holds the timer; level mode raises the request
    irq0_n <= 1'b0;
    wr_reg(MODE_ADDR, 8'h0a);
    wr_reg(T0_LOW_ADDR, 8'h00);
    wr_reg(CONTROL_ADDR, 8'h10);
    cycles(20);
    check(edg0, 1);
    rd_check(T0_LOW_ADDR, 8'h00);
    irq0_n <= 1'b1;
    cycles(20);
    wr_reg(CONTROL_ADDR, 8'h00);
    i_cpu_core_model.sfr_read(T0_LOW_ADDR, v);
    check(v != 8'h00, 1);
    // falling-edge request and its clear on vectoring
    wr_reg(CONTROL_ADDR, 8'h01);
    cycles(4);
    check(edg0, 0);
    irq0_n <= 1'b0;
    cycles(5);
    check(edg0, 1);
    i_cpu_core_model.vector(2);
    cycles(2);
    check(edg0, 0);
    check({edg1, out1}, 0);
    irq0_n <= 1'b1;
    wr_reg(CONTROL_ADDR, 8'h00);
    // mode 0 with the reset width: 5 low bits, 32 ticks to overflow
    wr_reg(MODE_ADDR, 8'h00);
    wr_reg(T0_LOW_ADDR, 8'h00);
    wr_reg(T0_HIGH_ADDR, 8'hff);
    wr_reg(CONTROL_ADDR, 8'h10);
    cycles(25);
    check(ovf0, 0);
    wait_sig(0, 15);
    wr_reg(CONTROL_ADDR, 8'h00);
    rd_check(T0_HIGH_ADDR, 8'h00);
    // mode 1 reload from the reload pair
    wr_reg(T0_RLOW_ADDR, 8'hf0);
    wr_reg(T0_RHIGH_ADDR, 8'hff);
    wr_reg(T0_LOW_ADDR, 8'hfe);
    wr_reg(T0_HIGH_ADDR, 8'hff);
    wr_reg(MODE_ADDR, 8'h01);
    wr_reg(CONTROL_ADDR, 8'h10);
    wait_sig(0, 20);
    wr_reg(CONTROL_ADDR, 8'h00);
    rd_check(T0_HIGH_ADDR, 8'hff);
    i_cpu_core_model.sfr_read(T0_LOW_ADDR, v);
    check(v >= 8'hf0, 1);
    // split timer 0, timer 1 held in its own mode 3
    wr_reg(MODE_ADDR, 8'h33);
    wr_reg(T1_LOW_ADDR, 8'h00);
    wr_reg(T0_LOW_ADDR, 8'h00);
    wr_reg(T0_HIGH_ADDR, 8'hf8);
    wr_reg(CONTROL_ADDR, 8'h40);
    wait_sig(1, 20);
    wr_reg(CONTROL_ADDR, 8'h80);
    rd_check(T1_LOW_ADDR, 8'h00);
    rd_check(T0_LOW_ADDR, 8'h00);
    check(ovf0, 0);
    wr_reg(CONTROL_ADDR, 8'h00);
    // pulse on timer 0: mode 0, width field 0, period 512 cycles
    wr_reg(T0_RHIGH_ADDR, 8'h40);
    wr_reg(MODE_ADDR, 8'h00);
    wr_reg(SECOND_ADDR, 8'h40);
    // pin enable is registered one cycle behind the control byte
    cycles(1);
    @(negedge clock_in);
    check({oe1, oe0}, 2'b01);
    wr_reg(CONTROL_ADDR, 8'h10);
    // the latch may still hold an old duty, so allow a full period to drop
    wait_sig(2, 1200);
    wait_sig(3, 1200);
    count_high(n);
    check(n[15:0], 128);
    fork
      count_high(m);
      begin
        cycles(10);
        wr_reg(T0_RHIGH_ADDR, 8'h80);
      end
    join
    check(m[15:0], 128);
    count_high(n);
    check(n[15:0], 256);
    check(ovf0, 1);
    wr_reg(T0_RHIGH_ADDR, 8'h00);
    cycles(1100);
    count_high(n);
    check(n[15:0], 0);
    end_of_test();
  end
endmodule

// >>> timer_pkg.sv
// constants shared by the dual timer/counter with pulse outputs
package timer_pkg;
  // register addresses on the special function register port
  localparam logic [7:0] CONTROL_ADDR  = 8'h88;
  localparam logic [7:0] MODE_ADDR     = 8'h89;
  localparam logic [7:0] T0_LOW_ADDR   = 8'h8a;
  localparam logic [7:0] T1_LOW_ADDR   = 8'h8b;
  localparam logic [7:0] T0_HIGH_ADDR  = 8'h8c;
  localparam logic [7:0] T1_HIGH_ADDR  = 8'h8d;
  localparam logic [7:0] DIVIDER_ADDR  = 8'h8f;
  localparam logic [7:0] SECOND_ADDR   = 8'h91;
  localparam logic [7:0] T0_RLOW_ADDR  = 8'h92;
  localparam logic [7:0] T1_RLOW_ADDR  = 8'h93;
  localparam logic [7:0] T0_RHIGH_ADDR = 8'h94;
  localparam logic [7:0] T1_RHIGH_ADDR = 8'h95;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] SECOND_RESET  = 8'h24;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [3:0] DIVIDER_RESET = 4'h0;
  // timer_control bit positions
  localparam int OVF1_BIT = 7;
  localparam int RUN1_BIT = 6;
  localparam int OVF0_BIT = 5;
  localparam int RUN0_BIT = 4;
  localparam int EDG1_BIT = 3;
  localparam int TYP1_BIT = 2;
  localparam int EDG0_BIT = 1;
  localparam int TYP0_BIT = 0;
  // timer_mode field positions, timer 1 nibble sits four bits higher
  localparam int GATE_BIT = 3;
  localparam int SEL_BIT  = 2;
  localparam int MODE_LSB = 0;
  localparam int T1_SHIFT = 4;
  // timer_control_second field positions
  localparam int PULSE1_BIT = 7;
  localparam int PULSE0_BIT = 6;
  localparam int WIDTH1_LSB = 3;
  localparam int WIDTH0_LSB = 0;
  // counting modes
  localparam logic [1:0] MODE_VAR   = 2'h0;
  localparam logic [1:0] MODE_16    = 2'h1;
  localparam logic [1:0] MODE_8RL   = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
endpackage
